//--- wdt_params.svh
/*
 * offsets, field positions, reset values and key of the watchdog
 * register interface; assumes 12-bit byte addresses on the apb side
 */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_OFS_LOAD 12'h000
`define WDT_OFS_COUNT 12'h004
`define WDT_OFS_CTRL 12'h008
`define WDT_OFS_ICLR 12'h00c
`define WDT_OFS_RIS 12'h010
`define WDT_OFS_MIS 12'h014
`define WDT_OFS_STALL 12'h418
`define WDT_OFS_LOCK 12'hc00
`define WDT_OFS_ID4 12'hfd0
`define WDT_OFS_ID5 12'hfd4

`define WDT_CTRL_TIMEOUT_IRQ_ENABLE_BIT 0
`define WDT_CTRL_RESET_OUTPUT_ENABLE_BIT 1
`define WDT_STALL_BIT 8
`define WDT_STATUS_BIT 0

`define WDT_LOAD_RESET 32'h0fffffff
`define WDT_COUNT_RESET 32'h0fffffff
`define WDT_UNLOCK_KEY 32'h1acce551
`define WDT_LOCKED_VAL 32'h00000001
`define WDT_UNLOCKED_VAL 32'h00000000

`endif

//--- wdt_pkg.sv
/*
 * types shared by the watchdog register interface;
 * assumes nothing of its surroundings
 */
package wdt_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_RUN = 4'b0010,
        ST_PEND = 4'b0100,
        ST_RESET = 4'b1000
    } wdt_state_t;

    typedef enum logic [3:0] {
        SEL_LOAD = 4'h0,
        SEL_COUNT = 4'h1,
        SEL_CTRL = 4'h2,
        SEL_ICLR = 4'h3,
        SEL_RIS = 4'h4,
        SEL_MIS = 4'h5,
        SEL_STALL = 4'h6,
        SEL_LOCK = 4'h7,
        SEL_ID4 = 4'h8,
        SEL_ID5 = 4'h9,
        SEL_NONE = 4'hf
    } wdt_sel_t;
endpackage : wdt_pkg

//--- wdt_decode.sv
/*
 * apb address decoder of the watchdog registers;
 * assumes a byte address whose low two bits select no register
 */
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_decode import wdt_pkg::*; #(
    parameter int ADDR_W = 12
) (
    input wire logic [ADDR_W-1:0] addr,
    output wdt_sel_t sel,
    output logic mapped
);
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : hit

    assign sel = hit(addr, `WDT_OFS_LOAD) ? SEL_LOAD :
                 hit(addr, `WDT_OFS_COUNT) ? SEL_COUNT :
                 hit(addr, `WDT_OFS_CTRL) ? SEL_CTRL :
                 hit(addr, `WDT_OFS_ICLR) ? SEL_ICLR :
                 hit(addr, `WDT_OFS_RIS) ? SEL_RIS :
                 hit(addr, `WDT_OFS_MIS) ? SEL_MIS :
                 hit(addr, `WDT_OFS_STALL) ? SEL_STALL :
                 hit(addr, `WDT_OFS_LOCK) ? SEL_LOCK :
                 hit(addr, `WDT_OFS_ID4) ? SEL_ID4 :
                 hit(addr, `WDT_OFS_ID5) ? SEL_ID5 : SEL_NONE;
    assign mapped = (sel != SEL_NONE);
endmodule : wdt_decode

//--- wdt_counter.sv
/*
 * 32-bit down counter with synchronous reload;
 * assumes reload has priority over the decrement
 */
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_counter #(
    parameter int WIDTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic reload,
    input wire logic [WIDTH-1:0] reload_val,
    input wire logic dec,
    output logic [WIDTH-1:0] count,
    output logic zero
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    assign count_next = reload ? reload_val :
                        (dec && count_reg != '0) ?
                        count_reg - WIDTH'(1) : count_reg;
    assign count = count_reg;
    assign zero = (count_reg == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= WIDTH'(`WDT_COUNT_RESET);
        end else if (ce) begin
            count_reg <= count_next;
        end
    end
endmodule : wdt_counter

//--- wdt_top.sv
/*
 * watchdog timer register interface: apb slave, control and lock
 * registers, time-out sequencing, interrupt and system reset outputs.
 * assumes apb signals synchronous to pclk and a level cpu_halted from
 * the debug logic
 */
// The APB register port was decided locally.
// Behaviour
// [RQ1] count register reads live counter, ignores writes
// [RQ2] control writes ignored once interrupt enabled
// [RQ3] bit 1 gates reset on second time-out
// [RQ4] bit 0 sticky until hardware reset
// [RQ5] interrupt clear write clears irq, reloads
// [RQ6] software ignores interrupt clear read value
// [RQ7] raw status bit shows unmasked interrupt
// [RQ8] masked status is raw AND enable
// [RQ9] unlock key opens writes to registers
// [RQ10] other lock value blocks register writes
// [RQ11] lock read returns one locked, zero open
// [RQ12] stall bit freezes counter while halted
// [RQ13] software preserves reserved bits
// [RQ14] ident registers fixed, byte in 7:0
// [RQ15] first time-out raises irq and reloads
// [RQ16] second time-out uncleared asserts system reset
// [RQ17] load write reloads counter; zero fires
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_top import wdt_pkg::*; #(
    parameter int ADDR_W = 12,
    parameter int COUNT_W = 32,
    // arbitrary identification values
    parameter logic [7:0] IDENT_FOUR = 8'h5a,
    parameter logic [7:0] IDENT_FIVE = 8'ha5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_halted,
    output logic timeout_interrupt,
    output logic system_reset
);
    wdt_state_t state_reg;
    wdt_state_t state_next;
    wdt_sel_t sel;
    logic mapped;

    logic [31:0] reload_value_reg;
    logic timeout_irq_enable_reg;
    logic reset_output_enable_reg;
    logic stall_enable_reg;
    logic locked_reg;
    logic raw_irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_out_reg;
    logic sys_reset_reg;

    logic [COUNT_W-1:0] count_val;
    logic count_zero;

    // apb phase decode
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready_reg;
    wire wr_access = access_done && pwrite;
    wire wr_allowed = wr_access && (!locked_reg || sel == SEL_LOCK); // RQ10

    wire wr_load = wr_allowed && sel == SEL_LOAD;
    wire wr_ctrl = wr_allowed && sel == SEL_CTRL
                   && !timeout_irq_enable_reg; // RQ2
    wire wr_iclr = wr_allowed && sel == SEL_ICLR;
    wire wr_stall = wr_allowed && sel == SEL_STALL;
    wire wr_lock = wr_access && sel == SEL_LOCK;

    wire enable_rise = wr_ctrl && pwdata[`WDT_CTRL_TIMEOUT_IRQ_ENABLE_BIT];
    wire counting = timeout_irq_enable_reg && state_reg != ST_RESET;
    wire stalled = stall_enable_reg && cpu_halted;
    wire timeout_evt = counting && count_zero && !stalled;

    wire mis_bit = raw_irq_reg && timeout_irq_enable_reg; // RQ8

    wire counter_reload = wr_load || wr_iclr || enable_rise
                          || timeout_evt;
    wire [COUNT_W-1:0] counter_src = wr_load ? pwdata[COUNT_W-1:0] :
                                     reload_value_reg[COUNT_W-1:0];
    wire counter_dec = counting && !stalled;

    wire raw_irq_next = (timeout_evt && state_reg != ST_RESET)
                        || (raw_irq_reg && !wr_iclr);
    wire ctl_en_next = timeout_irq_enable_reg
                       || (wr_ctrl && pwdata[`WDT_CTRL_TIMEOUT_IRQ_ENABLE_BIT]);

    // read data, reserved bits as zero
    wire [31:0] rd_mux =
        (sel == SEL_LOAD) ? reload_value_reg :
        (sel == SEL_COUNT) ? 32'(count_val) :
        (sel == SEL_CTRL) ? {30'h0, reset_output_enable_reg,
                             timeout_irq_enable_reg} :
        (sel == SEL_RIS) ? {31'h0, raw_irq_reg} :
        (sel == SEL_MIS) ? {31'h0, mis_bit} :
        (sel == SEL_STALL) ? {23'h0, stall_enable_reg, 8'h00} :
        (sel == SEL_LOCK) ? (locked_reg ? `WDT_LOCKED_VAL :
                             `WDT_UNLOCKED_VAL) :
        (sel == SEL_ID4) ? {24'h0, IDENT_FOUR} :
        (sel == SEL_ID5) ? {24'h0, IDENT_FIVE} : 32'h0;

    wdt_decode #(
        .ADDR_W(ADDR_W)
    ) u_decode (
        .addr(paddr),
        .sel(sel),
        .mapped(mapped)
    );

    wdt_counter #(
        .WIDTH(COUNT_W)
    ) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .reload(counter_reload), // RQ5 RQ15 RQ17
        .reload_val(counter_src),
        .dec(counter_dec), // RQ12
        .count(count_val),
        .zero(count_zero)
    );

    // time-out sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (enable_rise) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (timeout_evt) begin
                    state_next = ST_PEND; // RQ15
                end
            end
            ST_PEND: begin
                if (timeout_evt && reset_output_enable_reg) begin
                    state_next = ST_RESET; // RQ3 RQ16
                end else if (wr_iclr && !timeout_evt) begin
                    state_next = ST_RUN;
                end
            end
            ST_RESET: begin
                state_next = ST_RESET;
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_OFF;
            raw_irq_reg <= 1'b0;
            irq_out_reg <= 1'b0;
            sys_reset_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            raw_irq_reg <= raw_irq_next; // RQ5 RQ7 RQ15
            irq_out_reg <= raw_irq_next && ctl_en_next;
            sys_reset_reg <= (state_next == ST_RESET);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_value_reg <= `WDT_LOAD_RESET;
        end else if (ce && wr_load) begin
            reload_value_reg <= pwdata; // RQ17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_irq_enable_reg <= 1'b0;
            reset_output_enable_reg <= 1'b0;
        end else if (ce && wr_ctrl) begin
            timeout_irq_enable_reg <= pwdata[`WDT_CTRL_TIMEOUT_IRQ_ENABLE_BIT]; // RQ4
            reset_output_enable_reg <= pwdata[`WDT_CTRL_RESET_OUTPUT_ENABLE_BIT]; // RQ2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_enable_reg <= 1'b0;
        end else if (ce && wr_stall) begin
            stall_enable_reg <= pwdata[`WDT_STALL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_reg <= 1'b0;
        end else if (ce && wr_lock) begin
            locked_reg <= (pwdata != `WDT_UNLOCK_KEY); // RQ9 RQ10
        end
    end

    // one wait-free answer: data captured in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && !mapped;
            if (setup_phase && !pwrite) begin
                prdata_reg <= rd_mux; // RQ1 RQ11 RQ14
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign timeout_interrupt = irq_out_reg; // RQ8
    assign system_reset = sys_reset_reg;

    property p_count_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && setup_phase && !pwrite && sel == SEL_COUNT)
        |=> (prdata == 32'($past(count_val)));
    endproperty
    a_count_read: assert property (p_count_read) // RQ1
        else $error("count read does not return live counter");

    property p_ctrl_frozen;
        @(posedge pclk) disable iff (!presetn)
        (ce && timeout_irq_enable_reg && wr_access && sel == SEL_CTRL)
        |=> $stable(reset_output_enable_reg) && timeout_irq_enable_reg;
    endproperty
    a_ctrl_frozen: assert property (p_ctrl_frozen) // RQ2
        else $error("control changed after interrupt enable");

    property p_reset_gated;
        @(posedge pclk) disable iff (!presetn)
        $rose(system_reset) |-> $past(reset_output_enable_reg)
        && $past(raw_irq_reg);
    endproperty
    a_reset_gated: assert property (p_reset_gated) // RQ3
        else $error("system reset without reset enable");

    property p_enable_sticky;
        @(posedge pclk) disable iff (!presetn)
        timeout_irq_enable_reg |=> timeout_irq_enable_reg;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) // RQ4
        else $error("interrupt enable cleared without reset");

    property p_iclr;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_iclr && !timeout_evt && !wr_load)
        |=> !raw_irq_reg && count_val == $past(reload_value_reg);
    endproperty
    a_iclr: assert property (p_iclr) // RQ5
        else $error("interrupt clear did not clear and reload");

    property p_ris_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && setup_phase && !pwrite && sel == SEL_RIS)
        |=> prdata == {31'h0, $past(raw_irq_reg)};
    endproperty
    a_ris_read: assert property (p_ris_read) // RQ7
        else $error("raw status read wrong");

    property p_mis;
        @(posedge pclk) disable iff (!presetn)
        (ce && setup_phase && !pwrite && sel == SEL_MIS)
        |=> prdata[0] == ($past(raw_irq_reg)
                          && $past(timeout_irq_enable_reg));
    endproperty
    a_mis: assert property (p_mis) // RQ8
        else $error("masked status not raw and enable");

    property p_unlock;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_lock && pwdata == `WDT_UNLOCK_KEY) |=> !locked_reg;
    endproperty
    a_unlock: assert property (p_unlock) // RQ9
        else $error("key did not unlock");

    property p_lock_blocks;
        @(posedge pclk) disable iff (!presetn)
        (ce && locked_reg && wr_access && sel == SEL_LOAD)
        |=> $stable(reload_value_reg);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) // RQ10
        else $error("write passed while locked");

    property p_lock_read;
        @(posedge pclk) disable iff (!presetn)
        (ce && setup_phase && !pwrite && sel == SEL_LOCK)
        |=> prdata == {31'h0, $past(locked_reg)};
    endproperty
    a_lock_read: assert property (p_lock_read) // RQ11
        else $error("lock read not lock status");

    property p_stall;
        @(posedge pclk) disable iff (!presetn)
        (ce && stalled && !counter_reload) |=> $stable(count_val);
    endproperty
    a_stall: assert property (p_stall) // RQ12
        else $error("counter moved while stalled");

    property p_first_timeout;
        @(posedge pclk) disable iff (!presetn)
        (ce && timeout_evt && state_reg == ST_RUN && !wr_load)
        |=> raw_irq_reg && state_reg == ST_PEND
        && count_val == $past(reload_value_reg);
    endproperty
    a_first_timeout: assert property (p_first_timeout) // RQ15
        else $error("first time-out did not raise and reload");

    property p_second_timeout;
        @(posedge pclk) disable iff (!presetn)
        (ce && timeout_evt && state_reg == ST_PEND
         && reset_output_enable_reg) |=> system_reset;
    endproperty
    a_second_timeout: assert property (p_second_timeout) // RQ16
        else $error("second time-out did not reset");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_load) |=> count_val == $past(pwdata);
    endproperty
    a_load: assert property (p_load) // RQ17
        else $error("load write did not reload counter");
endmodule : wdt_top

//--- testbench.sv
/*
 * self-checking bench of the watchdog register interface over apb;
 * assumes wdt_top with zero-wait apb and register outputs
 */
`timescale 1ns/1ps
`include "wdt_params.svh"

module testbench import wdt_pkg::*;;
    logic pclk, presetn, ce, psel, penable, pwrite, cpu_halted;
    logic [11:0] paddr;
    logic [31:0] pwdata, rnd;
    logic [31:0] prdata;
    logic pready, pslverr, timeout_interrupt, system_reset;
    logic [32:0] exp_q[$];
    int n_fail, checked, k;
    // arbitrary identification values
    localparam logic [7:0] ID_FOUR = 8'h3c;
    localparam logic [7:0] ID_FIVE = 8'hc3;

    wdt_top #(
        .IDENT_FOUR(ID_FOUR),
        .IDENT_FIVE(ID_FIVE)
    ) wdt_top_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halted(cpu_halted),
        .timeout_interrupt(timeout_interrupt),
        .system_reset(system_reset)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task summarize;
        $display("mismatches %0d, comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task check(input logic [32:0] seen, input logic [32:0] expd);
        checked++;
        if (seen !== expd) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    // one apb transfer, starting and ending just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] e, input logic err = 0);
        exp_q.push_back({err, e});
        xfer(1'b0, a, 32'h0);
    endtask : rd

    // cycles until irq (sel 0) or system reset (sel 1) is seen
    task wait_for(input logic sel, input int lim, output int n);
        logic seen;
        n = 0;
        seen = sel ? system_reset : timeout_interrupt;
        while (n < lim && seen !== 1'b1) begin
            @(posedge pclk);
            n++;
            seen = sel ? system_reset : timeout_interrupt;
        end
    endtask : wait_for

    task hw_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : hw_reset

    // read monitor: compares each completed read with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                check(33'h0, 33'h1);
            end else begin
                check({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_halted = 1'b0;
        rnd = $urandom(32'h0d92);
        hw_reset();
        rd(`WDT_OFS_COUNT, `WDT_COUNT_RESET);
        rd(`WDT_OFS_CTRL, 32'h0);
        rd(`WDT_OFS_RIS, 32'h0);
        rd(`WDT_OFS_MIS, 32'h0);
        rd(`WDT_OFS_STALL, 32'h0);
        rd(`WDT_OFS_LOCK, `WDT_UNLOCKED_VAL);
        rd(`WDT_OFS_ID4, {24'h0, ID_FOUR});
        rd(`WDT_OFS_ID5, {24'h0, ID_FIVE});
        rd(12'h020, 32'h0, 1'b1);
        wr(`WDT_OFS_COUNT, $urandom);
        rd(`WDT_OFS_COUNT, `WDT_COUNT_RESET);
        wr(`WDT_OFS_ID4, $urandom);
        rd(`WDT_OFS_ID4, {24'h0, ID_FOUR});
        // lock with a random non-key value, then try to write
        rnd = $urandom;
        if (rnd == `WDT_UNLOCK_KEY) begin
            rnd = rnd ^ 32'h1;
        end
        wr(`WDT_OFS_LOCK, rnd);
        rd(`WDT_OFS_LOCK, `WDT_LOCKED_VAL);
        wr(`WDT_OFS_LOAD, 32'h40);
        wr(`WDT_OFS_CTRL, 32'h1);
        rd(`WDT_OFS_LOAD, `WDT_LOAD_RESET);
        rd(`WDT_OFS_CTRL, 32'h0);
        wr(`WDT_OFS_LOCK, `WDT_UNLOCK_KEY);
        rd(`WDT_OFS_LOCK, `WDT_UNLOCKED_VAL);
        wr(`WDT_OFS_LOAD, 32'h40);
        rd(`WDT_OFS_LOAD, 32'h40);
        rd(`WDT_OFS_COUNT, 32'h40);
        wr(`WDT_OFS_STALL, 32'h100);
        rd(`WDT_OFS_STALL, 32'h100);
        // enable while halted: counter must stay at the load value
        cpu_halted <= 1'b1;
        wr(`WDT_OFS_CTRL, 32'h3);
        rd(`WDT_OFS_COUNT, 32'h40);
        rd(`WDT_OFS_CTRL, 32'h3);
        wr(`WDT_OFS_CTRL, 32'h0);
        rd(`WDT_OFS_CTRL, 32'h3);
        rd(`WDT_OFS_RIS, 32'h0);
        cpu_halted <= 1'b0;
        wait_for(1'b0, 200, k);
        check(k >= 60 && k <= 72, 1'b1);
        rd(`WDT_OFS_RIS, 32'h1);
        rd(`WDT_OFS_MIS, 32'h1);
        // clear while halted: reload must land exactly
        cpu_halted <= 1'b1;
        wr(`WDT_OFS_ICLR, $urandom);
        rd(`WDT_OFS_COUNT, 32'h40);
        rd(`WDT_OFS_RIS, 32'h0);
        check(timeout_interrupt, 1'b0);
        cpu_halted <= 1'b0;
        wait_for(1'b0, 200, k);
        check(system_reset, 1'b0);
        wait_for(1'b1, 200, k);
        check(k >= 60 && k <= 72, 1'b1);
        check(system_reset, 1'b1);
        // second run: reset output disabled, load of zero
        hw_reset();
        @(negedge pclk);
        check(system_reset, 1'b0);
        wr(`WDT_OFS_CTRL, 32'h1);
        wr(`WDT_OFS_LOAD, 32'h0);
        wait_for(1'b0, 5, k);
        check(k < 5, 1'b1);
        repeat (20) @(negedge pclk);
        check(system_reset, 1'b0);
        summarize();
    end
endmodule : testbench
